/* hdl/evsc_pkg.sv */
// constants for the exception vector and sleep control block
// assumes a 32-bit vector table reached by a single-word fetch port
//
// Function
// - table of 4-byte entries, one per vector
// - entry zero loads stack pointer only
// - reset at entry one, 1-15 internal
// - interrupt n sits at entry n+16
// - up to 256 entries, input 239 max
// - pc takes vector bit0 cleared, state bit0
// - bit0 zero above entry one posts invalid-state misuse fault
// - bad reset vector posts escalated fault
// - fixed numbering of core exceptions
// - sleep drops the clock-request output
// - request stays unless all three idle conditions
// - forced halt halts core, drops request
// - non-maskable input is tied inactive
// - per-input trigger, mask and priority
package evsc_pkg;
  localparam int unsigned ENTRY_BYTES   = 4;
  localparam int unsigned IRQ_BASE      = 16;
  localparam int unsigned TABLE_ENTRIES = 256;
  localparam logic [7:0] EXC_SP_INIT    = 8'h00;
  localparam logic [7:0] EXC_RESET      = 8'h01;
  localparam logic [7:0] EXC_NMI        = 8'h02;
  localparam logic [7:0] EXC_ESCALATED  = 8'h03;
  localparam logic [7:0] EXC_MEM_VIOL   = 8'h04;
  localparam logic [7:0] EXC_BUS_ERR    = 8'h05;
  localparam logic [7:0] EXC_MISUSE     = 8'h06;
  localparam logic [7:0] EXC_SUPV_CALL  = 8'h0B;
  localparam logic [7:0] EXC_DBG_MON    = 8'h0C;
  localparam logic [7:0] EXC_PEND_SVC   = 8'h0E;
  localparam logic [7:0] EXC_SYS_TICK   = 8'h0F;
  localparam int unsigned STATE_BIT     = 0;
  typedef enum logic [3:0] {
    EVSC_IDLE  = 4'b0001,
    EVSC_FETCH = 4'b0010,
    EVSC_LOAD  = 4'b0100,
    EVSC_HALT  = 4'b1000
  } evsc_state_t;
endpackage

/* hdl/evsc_top.sv */
// exception vector lookup, vector fetch and clock-request handshake
// assumes the vector memory answers a fetch request one or more cycles later
`timescale 1ns/100ps
module evsc_top #(
  parameter int unsigned NUM_IRQ = 240
) (
  input  wire logic         REF_CLK_I,
  input  wire logic         RST_I,
  input  wire logic         CE_I,
  input  wire logic         EXC_REQ_I,
  input  wire logic         EXC_IS_IRQ_I,
  input  wire logic [7:0]   EXC_NUM_I,
  input  wire logic         NMI_I,
  input  wire logic         VEC_ACK_I,
  input  wire logic [31:0]  VEC_DATA_I,
  input  wire logic [NUM_IRQ-1:0] IRQ_I,
  input  wire logic [NUM_IRQ-1:0] IRQ_EN_I,
  input  wire logic [NUM_IRQ-1:0] IRQ_LEVEL_I,
  input  wire logic [NUM_IRQ*3-1:0] IRQ_PRIO_I,
  input  wire logic         SLEEP_I,
  input  wire logic         SLEEP_PERMIT_I,
  input  wire logic         DEBUG_ACTIVE_I,
  input  wire logic         FORCE_HALT_I,
  output logic              VEC_REQ_O,
  output logic [31:0]       VEC_ADDR_O,
  output logic [31:0]       PC_O,
  output logic              PC_LOAD_O,
  output logic              INSTRUCTION_SET_STATE_BIT_O,
  output logic              SP_LOAD_O,
  output logic              INVALID_STATE_FAULT_FLAG_O,
  output logic              FAULT_POST_O,
  output logic [7:0]        FAULT_NUM_O,
  output logic [NUM_IRQ-1:0] IRQ_PEND_O,
  output logic [2:0]        TOP_PRIO_O,
  output logic              CORE_HALT_O,
  output logic              CLK_REQ_O
);

  evsc_pkg::evsc_state_t st_r, st_nxt;
  logic [7:0]  entry_r, entry_nxt;
  logic        req_r, req_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] pc_r, pc_nxt;
  logic        pcl_r, pcl_nxt, tbit_r, tbit_nxt, spl_r, spl_nxt;
  logic        inv_r, inv_nxt, fp_r, fp_nxt;
  logic [7:0]  fnum_r, fnum_nxt;
  logic        halt_r, halt_nxt, creq_r, creq_nxt;
  logic [NUM_IRQ-1:0] pend_r, pend_nxt, irq_d_r;
  logic [2:0]  prio_r, prio_nxt;
  logic        nmi_live;
  logic        any_pend;

  // non-maskable source is tied off at this level; NMI_I is never consulted
  assign nmi_live = 1'b0 & NMI_I;
  assign any_pend = |pend_r;

  // per-input trigger mode and mask; pulse inputs latch on a rising edge
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++) begin : g_irq
      always_comb begin
        if (IRQ_LEVEL_I[g])
          pend_nxt[g] = IRQ_I[g] & IRQ_EN_I[g];
        else if (IRQ_I[g] & ~irq_d_r[g] & IRQ_EN_I[g])
          pend_nxt[g] = 1'b1;
        // a request refused by forced halt is not taken, so it must not clear
        else if (EXC_REQ_I & EXC_IS_IRQ_I & ~FORCE_HALT_I & (EXC_NUM_I == 8'(g))
                 & (st_r == evsc_pkg::EVSC_IDLE))
          pend_nxt[g] = 1'b0;
        else
          pend_nxt[g] = pend_r[g] & IRQ_EN_I[g];
      end
    end
  endgenerate

  // highest priority level among pending inputs, for the arbiter outside
  always_comb begin
    prio_nxt = 3'h0;
    for (int i = 0; i < NUM_IRQ; i++)
      if (pend_r[i] && IRQ_PRIO_I[i*3 +: 3] > prio_nxt)
        prio_nxt = IRQ_PRIO_I[i*3 +: 3];
  end

  always_comb begin
    st_nxt   = st_r;
    entry_nxt = entry_r;
    req_nxt  = 1'b0;
    addr_nxt = addr_r;
    pc_nxt   = pc_r;
    pcl_nxt  = 1'b0;
    tbit_nxt = tbit_r;
    spl_nxt  = 1'b0;
    inv_nxt  = inv_r;
    fp_nxt   = 1'b0;
    fnum_nxt = fnum_r;
    halt_nxt = FORCE_HALT_I;
    unique case (st_r)
      evsc_pkg::EVSC_IDLE: begin
        if (FORCE_HALT_I) begin
          st_nxt = evsc_pkg::EVSC_HALT;
        end else if (EXC_REQ_I && (EXC_IS_IRQ_I ||
                     EXC_NUM_I != evsc_pkg::EXC_NMI || nmi_live)) begin
          // interrupts are offset past the core-internal entries
          entry_nxt = EXC_IS_IRQ_I ? 8'(EXC_NUM_I + 8'(evsc_pkg::IRQ_BASE))
                                   : EXC_NUM_I;
          addr_nxt = 32'(EXC_IS_IRQ_I ? 32'(EXC_NUM_I) + evsc_pkg::IRQ_BASE
                                     : 32'(EXC_NUM_I)) * evsc_pkg::ENTRY_BYTES;
          req_nxt  = 1'b1;
          st_nxt   = evsc_pkg::EVSC_FETCH;
        end
      end
      evsc_pkg::EVSC_FETCH: begin
        req_nxt = ~VEC_ACK_I;
        if (VEC_ACK_I) begin
          if (entry_r == evsc_pkg::EXC_SP_INIT) begin
            spl_nxt = 1'b1;
            st_nxt  = evsc_pkg::EVSC_IDLE;
          end else begin
            pc_nxt   = {VEC_DATA_I[31:1], 1'b0};
            tbit_nxt = VEC_DATA_I[evsc_pkg::STATE_BIT];
            pcl_nxt  = 1'b1;
            st_nxt   = evsc_pkg::EVSC_LOAD;
            if (!VEC_DATA_I[evsc_pkg::STATE_BIT]) begin
              fp_nxt = 1'b1;
              if (entry_r == evsc_pkg::EXC_RESET) begin
                fnum_nxt = evsc_pkg::EXC_ESCALATED;
              end else begin
                fnum_nxt = evsc_pkg::EXC_MISUSE;
                inv_nxt  = 1'b1;
              end
            end
          end
        end
      end
      evsc_pkg::EVSC_LOAD: begin
        st_nxt = evsc_pkg::EVSC_IDLE;
      end
      evsc_pkg::EVSC_HALT: begin
        if (!FORCE_HALT_I)
          st_nxt = evsc_pkg::EVSC_IDLE;
      end
      default: st_nxt = evsc_pkg::EVSC_IDLE;
    endcase
    // request held unless forced halt, or sleeping with nothing pending, permit given, debug idle
    if (FORCE_HALT_I)
      creq_nxt = 1'b0;
    else if (any_pend || !SLEEP_PERMIT_I || DEBUG_ACTIVE_I)
      creq_nxt = 1'b1;
    else
      creq_nxt = ~SLEEP_I;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r    <= evsc_pkg::EVSC_IDLE;
      entry_r <= 8'h00;
      req_r   <= 1'b0;
      addr_r  <= 32'h0000_0000;
      pc_r    <= 32'h0000_0000;
      pcl_r   <= 1'b0;
      tbit_r  <= 1'b0;
      spl_r   <= 1'b0;
      inv_r   <= 1'b0;
      fp_r    <= 1'b0;
      fnum_r  <= 8'h00;
      halt_r  <= 1'b0;
      creq_r  <= 1'b1;
      pend_r  <= '0;
      irq_d_r <= '0;
      prio_r  <= 3'h0;
    end else if (CE_I) begin
      st_r    <= st_nxt;
      entry_r <= entry_nxt;
      req_r   <= req_nxt;
      addr_r  <= addr_nxt;
      pc_r    <= pc_nxt;
      pcl_r   <= pcl_nxt;
      tbit_r  <= tbit_nxt;
      spl_r   <= spl_nxt;
      inv_r   <= inv_nxt;
      fp_r    <= fp_nxt;
      fnum_r  <= fnum_nxt;
      halt_r  <= halt_nxt;
      creq_r  <= creq_nxt;
      pend_r  <= pend_nxt;
      irq_d_r <= IRQ_I;
      prio_r  <= prio_nxt;
    end
  end

  assign VEC_REQ_O  = req_r;
  assign VEC_ADDR_O = addr_r;
  assign PC_O       = pc_r;
  assign PC_LOAD_O  = pcl_r;
  assign INSTRUCTION_SET_STATE_BIT_O = tbit_r;
  assign SP_LOAD_O  = spl_r;
  assign INVALID_STATE_FAULT_FLAG_O  = inv_r;
  assign FAULT_POST_O = fp_r;
  assign FAULT_NUM_O  = fnum_r;
  assign IRQ_PEND_O   = pend_r;
  assign TOP_PRIO_O   = prio_r;
  assign CORE_HALT_O  = halt_r;
  assign CLK_REQ_O    = creq_r;

  a_halt_drops_req: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CE_I && FORCE_HALT_I |=> !CLK_REQ_O && CORE_HALT_O)
    else $error("forced halt did not drop clock request");

  a_wake_raises_req: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CE_I && !FORCE_HALT_I && (!SLEEP_PERMIT_I || DEBUG_ACTIVE_I) |=> CLK_REQ_O)
    else $error("clock request not held for wake condition");

  a_sleep_drops_req: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CE_I && SLEEP_I && SLEEP_PERMIT_I && !DEBUG_ACTIVE_I && !any_pend
    |=> !CLK_REQ_O)
    else $error("sleep did not drop clock request");

  a_pc_bit0_clear: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CE_I && st_r == evsc_pkg::EVSC_FETCH && VEC_ACK_I && entry_r != evsc_pkg::EXC_SP_INIT
    |=> PC_LOAD_O && !PC_O[evsc_pkg::STATE_BIT]
        && INSTRUCTION_SET_STATE_BIT_O == $past(VEC_DATA_I[evsc_pkg::STATE_BIT]))
    else $error("pc load does not follow vector");

  sequence s_irq_taken;
    CE_I && st_r == evsc_pkg::EVSC_IDLE && !FORCE_HALT_I && EXC_REQ_I && EXC_IS_IRQ_I;
  endsequence
  a_irq_offset: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    s_irq_taken |=> VEC_REQ_O
      && VEC_ADDR_O == 32'(($past(EXC_NUM_I) + evsc_pkg::IRQ_BASE) * evsc_pkg::ENTRY_BYTES))
    else $error("interrupt vector address wrong");

  a_misuse_fault: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CE_I && st_r == evsc_pkg::EVSC_FETCH && VEC_ACK_I && !VEC_DATA_I[evsc_pkg::STATE_BIT]
    && entry_r > evsc_pkg::EXC_RESET
    |=> FAULT_POST_O && FAULT_NUM_O == evsc_pkg::EXC_MISUSE && INVALID_STATE_FAULT_FLAG_O)
    else $error("misuse fault not posted");

  a_reset_escal: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CE_I && st_r == evsc_pkg::EVSC_FETCH && VEC_ACK_I && !VEC_DATA_I[evsc_pkg::STATE_BIT]
    && entry_r == evsc_pkg::EXC_RESET
    |=> FAULT_POST_O && FAULT_NUM_O == evsc_pkg::EXC_ESCALATED)
    else $error("escalated fault not posted");

  a_entry0_sp: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    CE_I && st_r == evsc_pkg::EVSC_FETCH && VEC_ACK_I && entry_r == evsc_pkg::EXC_SP_INIT
    |=> SP_LOAD_O && !PC_LOAD_O)
    else $error("entry zero used as handler");

endmodule

/* verif/evsc_vec_mem.sv */
// vector memory model: answers each fetch request with one ack pulse
// assumes the requester holds its request until the ack edge
`timescale 1ns/100ps
module evsc_vec_mem (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [31:0] word_i,
  input  wire logic [3:0]  lat_i,
  output logic             ack_o,
  output logic [31:0]      data_o
);
  logic [3:0] cnt_r;
  // every entry answers, as if the table reaches the top input
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= 4'h0;
      ack_o  <= 1'b0;
      data_o <= 32'h0;
    end else if (req_i && !ack_o && cnt_r == lat_i) begin
      cnt_r  <= 4'h0;
      ack_o  <= 1'b1;
      data_o <= word_i;
    end else begin
      // released data bus toggles so a stale word is never read as valid
      cnt_r  <= (req_i && !ack_o) ? cnt_r + 4'h1 : 4'h0;
      ack_o  <= 1'b0;
      data_o <= ~data_o;
    end
  end
endmodule

/* verif/exception_vector_and_sleep_control_tb_top.sv */
// testbench for evsc_top: vector fetch, fault posting, clock request
// assumes evsc_vec_mem answers fetches; inputs move on falling edges
`timescale 1ns/100ps
module exception_vector_and_sleep_control_tb_top;
  logic         clk, rst, ce, req, irq, nmi, slp, prm, dbg, hlt, ack;
  logic [7:0]   num, fnum;
  logic [3:0]   lat;
  logic [31:0]  word, data, vaddr, pc;
  logic [239:0] src, en, pend, lvl;
  logic [719:0] prio;
  logic [7:0]   core [9] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0B, 8'h0C, 8'h0E, 8'h0F};
  logic [5:0]   wake [6] = '{6'h30, 6'h21, 6'h39, 6'h35, 6'h11, 6'h06};
  logic         vreq, pcl, spl, isb, ifl, fpost, chalt, creq;
  logic [2:0]   tprio;
  int           miscompares, n_checks;

  evsc_top i_dut (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce), .EXC_REQ_I(req),
    .EXC_IS_IRQ_I(irq), .EXC_NUM_I(num), .NMI_I(nmi), .VEC_ACK_I(ack), .VEC_DATA_I(data),
    .IRQ_I(src), .IRQ_EN_I(en), .IRQ_LEVEL_I(lvl), .IRQ_PRIO_I(prio),
    .SLEEP_I(slp), .SLEEP_PERMIT_I(prm), .DEBUG_ACTIVE_I(dbg), .FORCE_HALT_I(hlt),
    .VEC_REQ_O(vreq), .VEC_ADDR_O(vaddr), .PC_O(pc), .PC_LOAD_O(pcl),
    .INSTRUCTION_SET_STATE_BIT_O(isb), .SP_LOAD_O(spl), .INVALID_STATE_FAULT_FLAG_O(ifl),
    .FAULT_POST_O(fpost), .FAULT_NUM_O(fnum), .IRQ_PEND_O(pend), .TOP_PRIO_O(tprio),
    .CORE_HALT_O(chalt), .CLK_REQ_O(creq));
  evsc_vec_mem i_mem (.clk_i(clk), .rst_i(rst), .req_i(vreq), .word_i(word),
    .lat_i(lat), .ack_o(ack), .data_o(data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic fetch(input logic i, input logic [7:0] n, input logic [31:0] w);
    logic [7:0] e;
    int k;
    e = i ? n + 8'h10 : n;
    word = w;
    lat = n[3:0] & 4'h3;
    irq = i;
    num = n;
    req = 1'b1;
    k = 0;
    while (vreq !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    req = 1'b0;
    chk1(vreq, 1'b1);
    chk32(vaddr, {22'h0, e, 2'b00});
    k = 0;
    while (pcl !== 1'b1 && spl !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    if (e == 8'h00) begin
      chk1(spl, 1'b1);
      chk1(pcl, 1'b0);
    end else begin
      chk1(pcl, 1'b1);
      chk32(pc, {w[31:1], 1'b0});
      chk1(isb, w[0]);
      chk1(fpost, ~w[0]);
      if (!w[0]) chk32({24'h0, fnum}, (e == 8'h01) ? 32'h3 : 32'h6);
    end
    repeat (2) @(negedge clk);
  endtask

  task automatic refuse_nmi;
    nmi = 1'b1;
    irq = 1'b0;
    num = 8'h02;
    req = 1'b1;
    repeat (6) begin
      @(negedge clk);
      chk1(vreq, 1'b0);
    end
    req = 1'b0;
    nmi = 1'b0;
  endtask

  // a reset in mid-run must clear the sticky fault flag and restore the request
  task automatic reset_mid;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk1(ifl, 1'b0);
    chk1(vreq, 1'b0);
    chk1(creq, 1'b1);
    rst = 1'b0;
    @(negedge clk);
  endtask

  // input 7 is pulse triggered at priority 6: masked, latched, cleared on take
  task automatic pulse_irq;
    en[7] = 1'b0;
    src[7] = 1'b1;
    @(negedge clk);
    src[7] = 1'b0;
    repeat (2) @(negedge clk);
    chk1(pend[7], 1'b0);
    en[7] = 1'b1;
    src[7] = 1'b1;
    @(negedge clk);
    src[7] = 1'b0;
    repeat (2) @(negedge clk);
    chk1(pend[7], 1'b1);
    chk32({29'h0, tprio}, 32'h6);
    fetch(1'b1, 8'h07, 32'h0000_0701);
    chk1(pend[7], 1'b0);
    chk32({29'h0, tprio}, 32'h0);
  endtask

  // chip clock control stops the clock only once the request has dropped
  task automatic ce_gate;
    {slp, prm, dbg, hlt} = 4'hC;
    repeat (2) @(negedge clk);
    chk1(creq, 1'b0);
    ce = creq;
    dbg = 1'b1;
    repeat (3) @(negedge clk);
    chk1(creq, 1'b0);
    ce = 1'b1;
    @(negedge clk);
    chk1(creq, 1'b1);
  endtask

  // c holds sleep, permit, debug, pending, halt, expected request
  task automatic wake_case(input logic [5:0] c);
    {slp, prm, dbg, src[5], hlt} = c[5:1];
    repeat (3) @(negedge clk);
    chk1(creq, c[0]);
    chk1(chalt, c[1]);
    chk1(pend[5], c[2]);
    if (c[2]) chk32({29'h0, tprio}, 32'h5);
  endtask

  initial begin
    {rst, req, irq, nmi, slp, prm, dbg, hlt} = 8'h80;
    {num, lat, word, src} = '0;
    ce = 1'b1;
    en = '1;
    lvl = '1;
    lvl[7] = 1'b0;
    prio = {240{3'h5}};
    prio[21 +: 3] = 3'h6;
    miscompares = 0;
    n_checks = 0;
    repeat (5) @(negedge clk);
    chk1(creq, 1'b1);
    rst = 1'b0;
    @(negedge clk);
    fetch(1'b0, 8'h00, 32'h2000_1000);
    foreach (core[j]) fetch(1'b0, core[j], {16'h0, core[j], 8'h01});
    fetch(1'b1, 8'h00, 32'h0001_0011);
    fetch(1'b1, 8'hEF, 32'h0001_FF01);
    fetch(1'b0, 8'h04, 32'h0000_0400);
    chk1(ifl, 1'b1);
    fetch(1'b0, 8'h01, 32'h0000_0200);
    reset_mid();
    refuse_nmi();
    pulse_irq();
    ce_gate();
    foreach (wake[j]) wake_case(wake[j]);
    complete_run();
  end

  initial begin
    #(8 * 4000);
    miscompares++;
    complete_run();
  end
endmodule
